// ---- rtl/gcp_debounce.sv ----
/*
 * button debouncer: two-flop synchroniser, then a level accepted only after
 * it stays stable for DB_MS millisecond ticks. press_r pulses when a high level is accepted.
 * assumes a one-cycle ms_tick enable on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module gcp_debounce #(
   parameter int unsigned DB_MS = gcp_pkg::DEBOUNCE_MS
) (
   input wire logic clock, // system clock
   input wire logic reset, // sync reset, high
   input wire logic ms_tick, // millisecond enable
   input wire logic pin, // raw button, high = pressed
   output logic level_r, // debounced level
   output logic press_r // pulse on accepted press
);
   localparam int W = $clog2(DB_MS + 1);
   logic s1_r, s2_r;
   logic [W-1:0] cnt_r;
   wire differ = s2_r != level_r;
   wire settled = differ && ms_tick && cnt_r == W'(DB_MS - 1);

   always_ff @(posedge clock) begin
      if (reset) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         cnt_r <= '0;
         level_r <= 1'b0;
         press_r <= 1'b0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         cnt_r <= (!differ || settled) ? '0 : cnt_r + W'(ms_tick);
         level_r <= settled ? s2_r : level_r;
         press_r <= settled && s2_r;
      end
   end
endmodule // gcp_debounce
`default_nettype wire

// ---- rtl/gcp_menu.sv ----
/*
 * front-panel programming menu of the slide gate controller, with the gate
 * behaviours its options steer (handedness, dual gate, auto close, hold loop,
 * auxiliary relay). assumes raw button and gate pins, and run requests from
 * the motor logic on the same clock; stored options start at factory defaults.
 */
`timescale 1ns/1ns
`default_nettype none
module gcp_menu #(
   parameter int unsigned CYC_PER_MS = gcp_pkg::CYC_PER_MS
) (
   input wire logic clock, // system clock, 100 mhz
   input wire logic reset, // sync reset, high
   input wire gcp_pkg::gcp_btn_s btn_pin, // raw buttons, high = pressed
   input wire gcp_pkg::gcp_gate_s gate_pin, // raw gate inputs
   input wire logic run_open_req, // motor logic wants open travel
   input wire logic run_close_req, // motor logic wants close travel
   output logic prog_led_r, // programming indicator
   output logic [6:0] disp_code_r, // function number or option code
   output logic disp_opt_r, // decimal points: option shown
   output logic disp_flash_r, // edit state, display flashing
   output logic disp_on_r, // display lit this instant
   output logic nv_wr_r, // pulse: write option to memory
   output logic [1:0] nv_func_r, // function being written
   output logic [6:0] nv_data_r, // option being written
   output gcp_pkg::gcp_cfg_s cfg_r, // stored options
   output logic motor_a_r, // drive toward side a
   output logic motor_b_r, // drive toward side b
   output logic aux_relay_r, // auxiliary relay coil
   output logic link_en_r, // inter_controller_link enabled
   output logic mid_stop_en_r, // mid-travel stop allowed
   output logic hold_open_r, // gate held open by loop
   output logic auto_close_r // pulse: start close run
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [6:0] opt_last(input logic [1:0] fn);
      return (fn == gcp_pkg::FN_ACL) ? gcp_pkg::ACL_LAST : gcp_pkg::BIN_LAST;
   endfunction

   function automatic logic [9:0] acl_secs(input logic [6:0] c);
      if (c <= gcp_pkg::ACL_SEC_MAX) return {3'h0, c};
      return 10'((c - gcp_pkg::ACL_SEC_MAX) * gcp_pkg::SEC_PER_MIN);
   endfunction

   // ****************************************
   // ticks, buttons, pin synchronisers
   // ****************************************
   logic ms_tick;
   logic up_lv, dn_lv, en_lv, up_p, dn_p, en_p;
   logic [3:0] gate_s1_r, gate_s2_r;
   gcp_pkg::gcp_gate_s gate;

   gcp_tick #(.DIV(CYC_PER_MS)) u_tick (
      .clock(clock),
      .reset(reset),
      .tick_r(ms_tick)
   );
   gcp_debounce u_db_up (
      .clock(clock), .reset(reset), .ms_tick(ms_tick),
      .pin(btn_pin.up), .level_r(up_lv), .press_r(up_p)
   );
   gcp_debounce u_db_dn (
      .clock(clock), .reset(reset), .ms_tick(ms_tick),
      .pin(btn_pin.down), .level_r(dn_lv), .press_r(dn_p)
   );
   gcp_debounce u_db_en (
      .clock(clock), .reset(reset), .ms_tick(ms_tick),
      .pin(btn_pin.enter), .level_r(en_lv), .press_r(en_p)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         gate_s1_r <= 4'h0;
         gate_s2_r <= 4'h0;
      end else begin
         gate_s1_r <= gate_pin;
         gate_s2_r <= gate_s1_r;
      end
   end
   assign gate = gate_s2_r;

   // ****************************************
   // menu timers
   // ****************************************
   gcp_pkg::gcp_state_e st_r, st_nxt;
   logic [10:0] hold_ms_r;
   logic [9:0] ms_in_s_r;
   logic [7:0] idle_s_r, blink_r;
   logic sec_tick_r, blink_ph_r;

   wire both = up_lv && dn_lv;
   wire any_press = up_p || dn_p || en_p;
   wire any_lv = up_lv || dn_lv || en_lv;
   wire prog = st_r inside {gcp_pkg::ST_ENTER, gcp_pkg::ST_FUNC, gcp_pkg::ST_VIEW,
                            gcp_pkg::ST_EDIT, gcp_pkg::ST_STORED};
   wire hold_cond = (st_r == gcp_pkg::ST_IDLE) ? both : (st_r == gcp_pkg::ST_VIEW && en_lv);
   wire [10:0] hold_lim = (st_r == gcp_pkg::ST_IDLE) ? 11'(gcp_pkg::ENTRY_HOLD_MS)
                                                     : 11'(gcp_pkg::EDIT_HOLD_MS);
   wire hold_hit = hold_cond && hold_ms_r == hold_lim;
   wire tmo = sec_tick_r && idle_s_r == 8'(gcp_pkg::IDLE_TIMEOUT_S - 1) && !any_press;
   wire s_wrap = ms_tick && ms_in_s_r == 10'(gcp_pkg::MS_PER_S - 1);
   wire b_wrap = ms_tick && blink_r == 8'(gcp_pkg::BLINK_MS - 1);

   always_ff @(posedge clock) begin
      if (reset) begin
         hold_ms_r <= 11'h000;
         ms_in_s_r <= 10'h000;
         sec_tick_r <= 1'b0;
         idle_s_r <= 8'h00;
         blink_r <= 8'h00;
         blink_ph_r <= 1'b1;
      end else begin
         hold_ms_r <= (!hold_cond || st_nxt != st_r) ? 11'h000
                    : hold_ms_r + 11'(ms_tick && !hold_hit);
         ms_in_s_r <= s_wrap ? 10'h000 : ms_in_s_r + 10'(ms_tick);
         sec_tick_r <= s_wrap;
         idle_s_r <= (!prog || any_press) ? 8'h00 : idle_s_r + 8'(sec_tick_r);
         blink_r <= b_wrap ? 8'h00 : blink_r + 8'(ms_tick);
         blink_ph_r <= (st_r != gcp_pkg::ST_EDIT) ? 1'b1 : blink_ph_r ^ b_wrap;
      end
   end

   // ****************************************
   // menu state machine
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      if (prog && st_r != gcp_pkg::ST_ENTER && both) begin
         st_nxt = gcp_pkg::ST_RELEASE;
      end else if (prog && tmo) begin
         st_nxt = gcp_pkg::ST_IDLE;
      end else begin
         unique case (st_r)
            gcp_pkg::ST_IDLE: begin
               if (hold_hit) st_nxt = gcp_pkg::ST_ENTER;
            end
            gcp_pkg::ST_ENTER: begin
               if (!any_lv) st_nxt = gcp_pkg::ST_FUNC;
            end
            gcp_pkg::ST_FUNC: begin
               if (en_p) st_nxt = gcp_pkg::ST_VIEW;
            end
            gcp_pkg::ST_VIEW: begin
               if (up_p || dn_p) st_nxt = gcp_pkg::ST_FUNC;
               else if (hold_hit) st_nxt = gcp_pkg::ST_EDIT;
            end
            gcp_pkg::ST_EDIT: begin
               if (en_p) st_nxt = gcp_pkg::ST_STORED;
            end
            gcp_pkg::ST_STORED: begin
               if (any_press) st_nxt = gcp_pkg::ST_FUNC;
            end
            gcp_pkg::ST_RELEASE: begin
               if (!up_lv && !dn_lv) st_nxt = gcp_pkg::ST_IDLE;
            end
            default: st_nxt = gcp_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // function, option and storage
   // ****************************************
   logic [1:0] fn_r;
   logic [6:0] opt_r;
   wire steady = !both && !tmo;
   wire in_func = st_r == gcp_pkg::ST_FUNC && steady;
   wire in_edit = st_r == gcp_pkg::ST_EDIT && steady;
   wire store = in_edit && en_p;
   wire [1:0] fn_up = (fn_r == gcp_pkg::FN_LAST) ? 2'h0 : fn_r + 2'h1;
   wire [1:0] fn_dn = (fn_r == 2'h0) ? gcp_pkg::FN_LAST : fn_r - 2'h1;
   wire [6:0] opt_up = (opt_r == opt_last(fn_r)) ? 7'h00 : opt_r + 7'h01;
   wire [6:0] opt_dn = (opt_r == 7'h00) ? opt_last(fn_r) : opt_r - 7'h01;
   wire [6:0] cur_opt = (fn_r == gcp_pkg::FN_HAND) ? {6'h00, cfg_r.left_hand}
                      : (fn_r == gcp_pkg::FN_DUAL) ? {6'h00, cfg_r.dual} : cfg_r.acl;
   wire [1:0] fn_nxt = (st_r == gcp_pkg::ST_ENTER) ? gcp_pkg::FN_HAND
                     : (in_func && up_p) ? fn_up
                     : (in_func && dn_p) ? fn_dn : fn_r;
   wire [6:0] opt_nxt = (in_func && en_p) ? cur_opt
                      : (in_edit && up_p) ? opt_up
                      : (in_edit && dn_p) ? opt_dn : opt_r;
   wire prog_nxt = st_nxt inside {gcp_pkg::ST_ENTER, gcp_pkg::ST_FUNC, gcp_pkg::ST_VIEW,
                                  gcp_pkg::ST_EDIT, gcp_pkg::ST_STORED};
   wire show_opt = st_nxt inside {gcp_pkg::ST_VIEW, gcp_pkg::ST_EDIT, gcp_pkg::ST_STORED};
   wire [6:0] code_nxt = show_opt ? opt_nxt : prog_nxt ? 7'(fn_nxt) + 7'h01 : 7'h00;

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= gcp_pkg::ST_IDLE;
         fn_r <= gcp_pkg::FN_HAND;
         opt_r <= 7'h00;
         cfg_r <= gcp_pkg::CFG_RESET;
         nv_wr_r <= 1'b0;
         nv_func_r <= 2'h0;
         nv_data_r <= 7'h00;
         prog_led_r <= 1'b0;
         disp_code_r <= 7'h00;
         disp_opt_r <= 1'b0;
         disp_flash_r <= 1'b0;
         disp_on_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         fn_r <= fn_nxt;
         opt_r <= opt_nxt;
         if (store && fn_r == gcp_pkg::FN_HAND) cfg_r.left_hand <= opt_r[0];
         if (store && fn_r == gcp_pkg::FN_DUAL) cfg_r.dual <= opt_r[0];
         if (store && fn_r == gcp_pkg::FN_ACL) cfg_r.acl <= opt_r;
         nv_wr_r <= store;
         nv_func_r <= store ? fn_r : nv_func_r;
         nv_data_r <= store ? opt_r : nv_data_r;
         prog_led_r <= prog_nxt;
         disp_code_r <= code_nxt;
         disp_opt_r <= show_opt;
         disp_flash_r <= st_nxt == gcp_pkg::ST_EDIT;
         disp_on_r <= prog_nxt && (st_nxt != gcp_pkg::ST_EDIT || blink_ph_r);
      end
   end

   // ****************************************
   // gate behaviour steered by the options
   // ****************************************
   logic [9:0] acl_cnt_r;
   logic acl_done_r;
   wire want_open = (run_open_req || gate.hold_loop) && !gate.open_lim;
   wire want_close = run_close_req && !gate.hold_loop && !want_open
                     && !gate.close_lim;
   wire acl_rst = !gate.open_lim || gate.hold_loop || cfg_r.acl == gcp_pkg::ACL_OFF;
   wire acl_fire = !acl_done_r && sec_tick_r && acl_cnt_r + 10'h001 == acl_secs(cfg_r.acl);

   always_ff @(posedge clock) begin
      if (reset) begin
         motor_a_r <= 1'b0;
         motor_b_r <= 1'b0;
         aux_relay_r <= 1'b0;
         link_en_r <= 1'b0;
         mid_stop_en_r <= 1'b1;
         hold_open_r <= 1'b0;
         acl_cnt_r <= 10'h000;
         acl_done_r <= 1'b0;
         auto_close_r <= 1'b0;
      end else begin
         motor_a_r <= cfg_r.left_hand ? want_close : want_open;
         motor_b_r <= cfg_r.left_hand ? want_open : want_close;
         aux_relay_r <= want_open || want_close;
         link_en_r <= cfg_r.dual;
         mid_stop_en_r <= !cfg_r.dual && !gate.open_in;
         hold_open_r <= gate.hold_loop;
         if (acl_rst) begin
            acl_cnt_r <= 10'h000;
            acl_done_r <= 1'b0;
         end else if (!gate.open_in && !acl_done_r) begin
            acl_cnt_r <= acl_cnt_r + 10'(sec_tick_r);
            acl_done_r <= acl_fire;
         end
         auto_close_r <= !acl_rst && !gate.open_in && acl_fire;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence view_held_s;
      st_r == gcp_pkg::ST_VIEW && hold_hit && steady && !up_p && !dn_p;
   endsequence
   sequence edit_entered_s;
      st_r == gcp_pkg::ST_EDIT && disp_flash_r && disp_opt_r;
   endsequence

   entry_hold_a: assert property ($rose(prog_led_r) |->
      $past(st_r) == gcp_pkg::ST_IDLE && $past(hold_ms_r) == 11'(gcp_pkg::ENTRY_HOLD_MS))
      else $error("programming entered without full hold");
   prog_led_a: assert property (prog_led_r |-> prog)
      else $error("indicator lit outside programming");
   exit_both_a: assert property ((prog && st_r != gcp_pkg::ST_ENTER && both)
      |=> !prog_led_r ##1 !prog_led_r)
      else $error("up and down together did not exit");
   idle_exit_a: assert property ((prog && tmo) |=> !prog_led_r)
      else $error("inactivity timeout did not exit");
   func_step_a: assert property ((in_func && up_p) |=> fn_r == $past(fn_up))
      else $error("function did not step up");
   view_dp_a: assert property ((in_func && en_p) |=>
      disp_opt_r && disp_code_r == $past(cur_opt))
      else $error("stored option not shown with points");
   edit_flash_a: assert property (view_held_s |=> edit_entered_s)
      else $error("enter hold did not start flashing edit");
   store_nv_a: assert property (store |=>
      nv_wr_r && nv_data_r == $past(opt_r) ##1 !nv_wr_r && st_r != gcp_pkg::ST_EDIT)
      else $error("option store pulse wrong");
   hand_swap_a: assert property ((want_open && cfg_r.left_hand) |=>
      motor_b_r && !motor_a_r)
      else $error("left hand open not swapped");
   dual_stop_a: assert property (cfg_r.dual |=> !mid_stop_en_r && link_en_r)
      else $error("mid-travel stop enabled in dual");
   acl_fire_a: assert property (auto_close_r |->
      acl_cnt_r == acl_secs($past(cfg_r.acl)) && $past(gate.open_lim))
      else $error("auto close at wrong count");
   acl_hold_a: assert property ((gate.open_in && !acl_rst) |=>
      $stable(acl_cnt_r) && !auto_close_r)
      else $error("open input did not suspend timer");
   hold_loop_a: assert property (gate.hold_loop |=>
      !($past(cfg_r.left_hand) ? motor_a_r : motor_b_r) && hold_open_r)
      else $error("gate closes while loop held");
   aux_run_a: assert property ((want_open || want_close) |=> aux_relay_r)
      else $error("aux relay idle during travel");
endmodule // gcp_menu
`default_nettype wire

// ---- rtl/gcp_pkg.sv ----
/*
 * shared constants, field layouts and types of the gate controller programming menu.
 * assumes a single 100 mhz clock; all time constants derive from it.
 */
package gcp_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int unsigned SEC_PER_MIN = 60;
   localparam int unsigned ENTRY_HOLD_S = 1;
   localparam int unsigned ENTRY_HOLD_MS = ENTRY_HOLD_S * MS_PER_S;
   localparam int unsigned EDIT_HOLD_S = 1;
   localparam int unsigned EDIT_HOLD_MS = EDIT_HOLD_S * MS_PER_S;
   localparam int unsigned IDLE_TIMEOUT_MIN = 3;
   localparam int unsigned IDLE_TIMEOUT_S = IDLE_TIMEOUT_MIN * SEC_PER_MIN;
   localparam int unsigned DEBOUNCE_MS = 20;
   localparam int unsigned BLINK_MS = 250;

   // ****************************************
   // functions and options
   // ****************************************
   localparam logic [1:0] FN_HAND = 2'h0;
   localparam logic [1:0] FN_DUAL = 2'h1;
   localparam logic [1:0] FN_ACL = 2'h2;
   localparam logic [1:0] FN_LAST = 2'h2;
   localparam logic [6:0] BIN_LAST = 7'h01;
   localparam logic [6:0] ACL_OFF = 7'h00;
   localparam logic [6:0] ACL_SEC_MAX = 7'h3b;
   localparam logic [6:0] ACL_LAST = 7'h44;

   typedef struct packed {
      logic up;
      logic down;
      logic enter;
   } gcp_btn_s;

   typedef struct packed {
      logic open_lim;
      logic close_lim;
      logic open_in;
      logic hold_loop;
   } gcp_gate_s;

   typedef struct packed {
      logic left_hand;
      logic dual;
      logic [6:0] acl;
   } gcp_cfg_s;

   localparam gcp_cfg_s CFG_RESET = '{left_hand: 1'b0, dual: 1'b0, acl: ACL_OFF};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ENTER = 3'b001,
      ST_FUNC = 3'b010,
      ST_VIEW = 3'b011,
      ST_EDIT = 3'b100,
      ST_STORED = 3'b101,
      ST_RELEASE = 3'b110
   } gcp_state_e;

endpackage

// ---- rtl/gcp_tick.sv ----
/*
 * free running divider: one-cycle enable pulse every DIV clock cycles.
 * assumes the system clock and synchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
module gcp_tick #(
   parameter int unsigned DIV = gcp_pkg::CYC_PER_MS
) (
   input wire logic clock, // system clock
   input wire logic reset, // sync reset, high
   output logic tick_r // one-cycle pulse
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_r;
   wire wrap = cnt_r == LAST;

   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= wrap ? '0 : cnt_r + 1'b1;
         tick_r <= wrap;
      end
   end
endmodule // gcp_tick
`default_nettype wire

// ---- tb/gcp_installer.sv ----
/*
 * installer model: presses the front-panel buttons of the programming menu.
 * assumes the system clock; a released button reads low at the pin.
 */
`timescale 1ns/1ns
`default_nettype none
module gcp_installer #(
   parameter int unsigned CYC_PER_MS = 2
) (
   input wire logic clock, // system clock
   output var gcp_pkg::gcp_btn_s btn // raw buttons, high = pressed
);
   // ****************************************
   // button actions
   // ****************************************
   initial begin
      btn = '0;
   end

   // holds the given buttons for ms, then leaves them released long enough to debounce
   task automatic hold(input gcp_pkg::gcp_btn_s which, input int unsigned ms);
      @(posedge clock);
      #1;
      btn = which;
      repeat (ms * CYC_PER_MS) @(posedge clock);
      #1;
      btn = '0;
      repeat (40 * CYC_PER_MS) @(posedge clock);
      #1;
   endtask
endmodule // gcp_installer
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 * self-checking bench of the programming menu and the gate behaviours it steers.
 * assumes gcp_menu with a shortened millisecond (CYC ms = 2 cycles) and the installer model.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) check_val(16'(got), 16'(exp))
module testbench;
   // ****************************************
   // signals and instances
   // ****************************************
   localparam int unsigned CYC = 2;
   localparam int S = 1000 * CYC;
   localparam gcp_pkg::gcp_btn_s B_UP = 3'h4;
   localparam gcp_pkg::gcp_btn_s B_DN = 3'h2;
   localparam gcp_pkg::gcp_btn_s B_EN = 3'h1;
   localparam gcp_pkg::gcp_btn_s B_UD = 3'h6;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic run_open_req = 1'b0;
   logic run_close_req = 1'b0;
   gcp_pkg::gcp_btn_s btn;
   gcp_pkg::gcp_gate_s gate = '0;
   gcp_pkg::gcp_cfg_s cfg_r;
   gcp_pkg::gcp_cfg_s exp_cfg = gcp_pkg::CFG_RESET;
   logic prog_led_r, disp_opt_r, disp_flash_r, nv_wr_r, motor_a_r, motor_b_r;
   logic aux_relay_r, link_en_r, mid_stop_en_r, hold_open_r, auto_close_r;
   logic [6:0] disp_code_r;
   logic disp_on_r;
   logic [1:0] nv_func_r;
   logic [6:0] nv_data_r;
   int miscompares = 0;
   int comparisons = 0;
   int nv_writes = 0;
   int seed = 32'haa99;
   int k, n, el;
   logic [1:0] fn = 2'h0;

   gcp_installer #(.CYC_PER_MS(CYC)) gcp_installer_i (.clock(clock), .btn(btn));

   gcp_menu #(.CYC_PER_MS(CYC)) gcp_menu_i (
      .clock(clock), .reset(reset), .btn_pin(btn), .gate_pin(gate),
      .run_open_req(run_open_req), .run_close_req(run_close_req),
      .prog_led_r(prog_led_r), .disp_code_r(disp_code_r), .disp_opt_r(disp_opt_r),
      .disp_flash_r(disp_flash_r), .disp_on_r(disp_on_r), .nv_wr_r(nv_wr_r),
      .nv_func_r(nv_func_r), .nv_data_r(nv_data_r), .cfg_r(cfg_r),
      .motor_a_r(motor_a_r), .motor_b_r(motor_b_r),
      .aux_relay_r(aux_relay_r), .link_en_r(link_en_r), .mid_stop_en_r(mid_stop_en_r),
      .hold_open_r(hold_open_r), .auto_close_r(auto_close_r));

   initial begin
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (nv_wr_r === 1'b1) nv_writes++;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   function automatic logic [6:0] opt_of(input gcp_pkg::gcp_cfg_s c, input logic [1:0] f);
      if (f == gcp_pkg::FN_HAND) return {6'h00, c.left_hand};
      if (f == gcp_pkg::FN_DUAL) return {6'h00, c.dual};
      return c.acl;
   endfunction

   function automatic logic [6:0] last_of(input logic [1:0] f);
      return (f == gcp_pkg::FN_ACL) ? gcp_pkg::ACL_LAST : gcp_pkg::BIN_LAST;
   endfunction

   task automatic step_up();
      gcp_installer_i.hold(B_UP, 40);
      fn = (fn == gcp_pkg::FN_LAST) ? 2'h0 : fn + 2'h1;
   endtask

   // selects function f, views it, edits it with kk up presses and stores it
   task automatic prog_fn(input logic [1:0] f, input int kk);
      logic [6:0] v;
      logic [1:0] seen;
      while (fn != f) step_up();
      `CHK(disp_code_r, fn + 7'h01);
      gcp_installer_i.hold(B_EN, 40);
      `CHK(disp_opt_r, 1'b1);
      `CHK(disp_code_r, opt_of(exp_cfg, f));
      gcp_installer_i.hold(B_EN, 1200);
      `CHK(disp_flash_r, 1'b1);
      seen = 2'h0;
      repeat (300 * CYC) begin
         @(posedge clock);
         #1;
         seen[disp_on_r] = 1'b1;
      end
      `CHK(seen, 2'h3);
      v = opt_of(exp_cfg, f);
      repeat (kk) begin
         gcp_installer_i.hold(B_UP, 40);
         v = (v == last_of(f)) ? 7'h00 : v + 7'h01;
      end
      `CHK(disp_code_r, v);
      gcp_installer_i.hold(B_EN, 40);
      if (f == gcp_pkg::FN_HAND) exp_cfg.left_hand = v[0];
      else if (f == gcp_pkg::FN_DUAL) exp_cfg.dual = v[0];
      else exp_cfg.acl = v;
      `CHK(cfg_r, exp_cfg);
      `CHK({nv_func_r, nv_data_r}, {f, v});
      `CHK(disp_flash_r, 1'b0);
      gcp_installer_i.hold(B_UP, 40);
      `CHK(disp_opt_r, 1'b0);
      `CHK(disp_code_r, fn + 7'h01);
   endtask

   // counts cycles until an auto close pulse, at most lim
   task automatic wait_pulse(input int lim, output int cyc);
      cyc = 0;
      while (cyc < lim && auto_close_r !== 1'b1) begin
         @(posedge clock);
         #1;
         cyc++;
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (90000) @(posedge clock);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (4) @(posedge clock);
      #1;
      reset = 1'b0;
      @(posedge clock);
      #1;
      `CHK(cfg_r, gcp_pkg::CFG_RESET);
      `CHK({prog_led_r, link_en_r, mid_stop_en_r}, 3'h1);
      gate.open_in = 1'b1;
      repeat (5) @(posedge clock);
      #1;
      `CHK(mid_stop_en_r, 1'b0);
      gate.open_in = 1'b0;
      repeat (5) @(posedge clock);
      #1;
      `CHK(mid_stop_en_r, 1'b1);
      $display("test reset done");

      gcp_installer_i.hold(B_UD, 600);
      `CHK(prog_led_r, 1'b0);
      gcp_installer_i.hold(B_UD, 1200);
      `CHK(prog_led_r, 1'b1);
      `CHK(disp_code_r, 7'h01);
      gcp_installer_i.hold(B_DN, 40);
      `CHK(disp_code_r, 7'h03);
      gcp_installer_i.hold(B_UP, 40);
      `CHK(disp_code_r, 7'h01);
      n = $unsigned($random(seed)) % 5;
      repeat (n) step_up();
      `CHK(disp_code_r, fn + 7'h01);
      $display("test entry and stepping done");

      k = $unsigned($random(seed)) % 3 + 1;
      prog_fn(gcp_pkg::FN_HAND, 1);
      prog_fn(gcp_pkg::FN_DUAL, 1);
      prog_fn(gcp_pkg::FN_ACL, k);
      gcp_installer_i.hold(B_EN, 1200);
      repeat (k + 1) gcp_installer_i.hold(B_DN, 40);
      `CHK(disp_code_r, gcp_pkg::ACL_LAST);
      `CHK(nv_writes, 3);
      `CHK(prog_led_r, 1'b1);
      gcp_installer_i.hold(B_UD, 40);
      `CHK(prog_led_r, 1'b0);
      `CHK({link_en_r, mid_stop_en_r}, 2'h2);
      $display("test programming done");

      run_open_req = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      `CHK({motor_a_r, motor_b_r, aux_relay_r}, 3'h3);
      run_open_req = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      `CHK(aux_relay_r, 1'b0);
      gate.hold_loop = 1'b1;
      run_close_req = 1'b1;
      repeat (5) @(posedge clock);
      #1;
      `CHK({hold_open_r, motor_a_r, motor_b_r}, 3'h5);
      run_close_req = 1'b0;
      gate.hold_loop = 1'b0;
      $display("test gate drive done");

      gate.open_lim = 1'b1;
      wait_pulse((k + 2) * S, el);
      `CHK(el > (k - 1) * S && el <= k * S + 8, 1'b1);
      gate.open_lim = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      gate.open_in = 1'b1;
      gate.open_lim = 1'b1;
      wait_pulse((k + 2) * S, el);
      `CHK(auto_close_r, 1'b0);
      gate.open_in = 1'b0;
      wait_pulse((k + 2) * S, el);
      `CHK(auto_close_r, 1'b1);
      $display("test auto close done");
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
